/* rdwg_ram_guard.sv */
// rdwg_ram_guard: 8 KiB ram on an ahb-lite slave port, six-channel dma arbiter, write guard
// assumes ahb-lite master on the same clock; dma masters hold req until their grant pulse
`timescale 1ns/1ps
// Summary of operation
// - 8 KiB ram decoded from 0x20000000
// - fetch and data, byte half word sizes
// - 32-bit path, zero wait normally
// - two wait states in fast clock mode
// - six dma channels reach the ram
// - serial rx and tx may pend together
// - fixed dma priority, cpu still served
// - one bitmap bit per 32-byte block
// - protected user write gives bus error
// - system writes and all reads allowed
// - enable bit extends check to dma
// - protected dma write raises interrupt, except from the sc1 and sc2 tx channels
// - capture fault address and peripheral id
// - only write channels can fault
module rdwg_ram_guard
  import rdwg_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hprot,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // configuration
  input wire logic fast_clk_mode,
  input wire logic dma_guard_en,
  input wire logic bitmap_we,
  input wire logic [7:0] bitmap_idx,
  input wire logic bitmap_val,
  output logic [255:0] bitmap,
  // dma channels, index = priority id
  input wire rdwg_dma_req_t dma_req [6],
  output logic [5:0] dma_gnt,
  output logic [31:0] dma_rdata,
  // fault capture
  input wire logic fault_clear,
  output logic dma_fault_irq,
  output rdwg_fault_t fault
);
  logic [31:0] mem [RDWG_WORDS];
  rdwg_bus_state_t state;
  logic [31:0] a_addr;
  logic [1:0] a_size;
  logic a_write;
  logic [1:0] wait_cnt;
  logic cpu_pend;
  logic cpu_wr_pend;
  logic cpu_turn;
  logic [2:0] dma_sel;
  logic dma_any;
  logic dma_go;
  logic [RDWG_WIDX_W-1:0] widx;
  logic [3:0] wstrb;
  logic [31:0] wdat;
  logic do_wr;
  logic dma_blocked;
  logic take;

  function automatic logic in_ram(input logic [31:0] a);
    return (a - RDWG_RAM_BASE) < 32'(RDWG_RAM_BYTES);
  endfunction
  function automatic logic [3:0] strobes(input logic [1:0] sz, input logic [1:0] lo);
    case (sz)
      RDWG_SZ_BYTE: strobes = 4'h1 << lo;
      RDWG_SZ_HALF: strobes = lo[1] ? 4'hc : 4'h3;
      default: strobes = 4'hf;
    endcase
  endfunction
  function automatic logic [7:0] blk(input logic [31:0] a);
    return a[RDWG_BLK_LSB +: RDWG_BLK_W];
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // ahb address phase for the ram
  assign take = hsel && hready && htrans[1] && in_ram(haddr);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= RDWG_IDLE;
      wait_cnt <= 2'h0;
      a_addr <= 32'h0;
      a_size <= 2'h0;
      a_write <= 1'b0;
    end else begin
      case (state)
        // second error cycle is ready, so it may take the next address
        RDWG_IDLE, RDWG_WAIT, RDWG_ERR2: begin
          if (state == RDWG_WAIT && (wait_cnt != 2'h0 || dma_go)) begin
            // cpu holds while wait states run or dma wins this slot
            if (wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
          end else if (take) begin
            a_addr <= haddr;
            a_size <= hsize[1:0];
            a_write <= hwrite;
            if (hwrite && !hprot[1] && bitmap[blk(haddr)]) begin
              state <= RDWG_ERR1;
            end else begin
              state <= RDWG_WAIT;
              wait_cnt <= fast_clk_mode ? RDWG_FAST_WAITS : 2'h0;
            end
          end else begin
            state <= RDWG_IDLE;
          end
        end
        RDWG_ERR1: state <= RDWG_ERR2;
        default: state <= RDWG_IDLE;
      endcase
    end
  end

  // cpu data phase finishes this cycle when no wait and it owns the ram
  assign cpu_pend = (state == RDWG_WAIT) && (wait_cnt == 2'h0);
  assign cpu_wr_pend = cpu_pend && a_write;

  // fixed priority among dma channels
  always_comb begin
    dma_sel = 3'h0;
    dma_any = 1'b0;
    for (int i = RDWG_NCH - 1; i >= 0; i--) begin
      if (dma_req[i].req) begin
        dma_sel = 3'(i);
        dma_any = 1'b1;
      end
    end
  end

  // cpu and dma alternate when both want the ram, so the cpu is never starved
  always_ff @(posedge clk) begin
    if (!reset_n) cpu_turn <= 1'b0;
    else if (cpu_pend && dma_any) cpu_turn <= !cpu_turn;
  end
  assign dma_go = dma_any && !(cpu_pend && cpu_turn);

  always_comb begin
    dma_gnt = 6'h0;
    if (dma_go) dma_gnt[dma_sel] = 1'b1;
  end

  // dma write guard; transmit channels are exempt and their writes land unchecked
  assign dma_blocked = dma_go && dma_req[dma_sel].write && dma_guard_en
    && bitmap[blk(dma_req[dma_sel].addr)]
    && dma_sel != RDWG_ID_SC1_TX && dma_sel != RDWG_ID_SC2_TX;

  // single ram port mux
  always_comb begin
    if (dma_go) begin
      widx = dma_req[dma_sel].addr[RDWG_WIDX_LSB +: RDWG_WIDX_W];
      wstrb = strobes(dma_req[dma_sel].size, dma_req[dma_sel].addr[1:0]);
      wdat = dma_req[dma_sel].wdata;
      do_wr = dma_req[dma_sel].write && !dma_blocked;
    end else begin
      widx = a_addr[RDWG_WIDX_LSB +: RDWG_WIDX_W];
      wstrb = strobes(a_size, a_addr[1:0]);
      wdat = hwdata;
      do_wr = cpu_wr_pend;
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb[b]) mem[widx][b*8 +: 8] <= wdat[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) dma_rdata <= 32'h0;
    else if (dma_go) dma_rdata <= mem[widx];
  end

  // cpu read sampled at its address edge, though it still waits out any fast mode wait states;
  // a write landing on the same word at that edge is merged in
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      if (do_wr && widx == haddr[RDWG_WIDX_LSB +: RDWG_WIDX_W]) begin
        hrdata <= merge(mem[widx], wdat, wstrb);
      end else begin
        hrdata <= mem[haddr[RDWG_WIDX_LSB +: RDWG_WIDX_W]];
      end
    end
  end

  // ready while idle, in the second error cycle, or when the cpu owns its slot
  assign hreadyout = (state == RDWG_IDLE) || (state == RDWG_ERR2)
    || (cpu_pend && !dma_go);
  assign hresp = (state == RDWG_ERR1) || (state == RDWG_ERR2);

  // bitmap
  always_ff @(posedge clk) begin
    if (!reset_n) bitmap <= '0;
    else if (bitmap_we) bitmap[bitmap_idx] <= bitmap_val;
  end

  // fault capture
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fault <= '0;
    end else if (dma_blocked && !fault.valid) begin
      fault.valid <= 1'b1;
      fault.addr <= dma_req[dma_sel].addr;
      fault.id <= dma_sel;
    end else if (fault_clear && !dma_blocked) begin
      fault.valid <= 1'b0;
    end
  end
  assign dma_fault_irq = fault.valid;
endmodule // rdwg_ram_guard

/* rdwg_pkg.sv */
// rdwg_pkg: constants and carriers for the ram dma arbiter and write guard
// assumes a single 250 MHz clock and synchronous active-low reset
package rdwg_pkg;
  localparam int unsigned RDWG_ADDR_W = 32;
  localparam int unsigned RDWG_DATA_W = 32;
  localparam logic [31:0] RDWG_RAM_BASE = 32'h2000_0000;
  localparam int unsigned RDWG_RAM_BYTES = 8192;
  localparam int unsigned RDWG_WORDS = RDWG_RAM_BYTES / 4;
  localparam int unsigned RDWG_WIDX_W = 11;
  localparam int unsigned RDWG_BLK_BYTES = 32;
  localparam int unsigned RDWG_BLOCKS = RDWG_RAM_BYTES / RDWG_BLK_BYTES;
  localparam int unsigned RDWG_BLK_W = 8;
  localparam int unsigned RDWG_BLK_LSB = 5;
  localparam int unsigned RDWG_WIDX_LSB = 2;
  localparam int unsigned RDWG_OFS_W = 13;
  localparam logic [1:0] RDWG_FAST_WAITS = 2'h2;
  localparam int unsigned RDWG_NCH = 6;
  localparam logic [2:0] RDWG_ID_ADC = 3'h0;
  localparam logic [2:0] RDWG_ID_SC2_RX = 3'h1;
  localparam logic [2:0] RDWG_ID_SC2_TX = 3'h2;
  localparam logic [2:0] RDWG_ID_MAC = 3'h3;
  localparam logic [2:0] RDWG_ID_SC1_RX = 3'h4;
  localparam logic [2:0] RDWG_ID_SC1_TX = 3'h5;
  localparam logic [2:0] RDWG_ID_CPU = 3'h7;
  // transfer size, as on the system bus
  localparam logic [1:0] RDWG_SZ_BYTE = 2'h0;
  localparam logic [1:0] RDWG_SZ_HALF = 2'h1;
  localparam logic [1:0] RDWG_SZ_WORD = 2'h2;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [31:0] wdata;
  } rdwg_dma_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [2:0]  id;
  } rdwg_fault_t;

  typedef enum logic [1:0] {RDWG_IDLE, RDWG_WAIT, RDWG_ERR1, RDWG_ERR2} rdwg_bus_state_t;
endpackage

/* rdwg_ram_guard_properties.sv */
// port checker for rdwg_ram_guard
// bound onto the top, one clock, sync reset
`timescale 1ns/1ps
module rdwg_ram_guard_properties
  import rdwg_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hresp,
  input wire logic hreadyout,
  input wire logic dma_guard_en,
  input wire rdwg_dma_req_t dma_req [6],
  input wire logic [5:0] dma_gnt,
  input wire logic fault_clear,
  input wire rdwg_fault_t fault,
  input wire logic dma_fault_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_one; $onehot0(dma_gnt); endproperty
  a_one: assert property (p_one) else $error("grants");
  property p_pri; dma_gnt[1] |-> dma_req[1].req && !dma_req[0].req; endproperty
  a_pri: assert property (p_pri) else $error("priority");
  property p_err; hresp && !hreadyout |=> hresp && hreadyout; endproperty
  a_err: assert property (p_err) else $error("error");
  property p_irq; $rose(dma_fault_irq) |-> $past(dma_guard_en) && $past(|dma_gnt); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_hold; fault.valid && !fault_clear |=> $stable(fault); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_clr; fault_clear && !(|dma_gnt) |=> !fault.valid; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_off; !dma_guard_en && !fault.valid |=> !fault.valid; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_cap; $rose(fault.valid) |-> $past(dma_gnt) == 6'h1 << fault.id; endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_tx;
    $rose(fault.valid) |-> fault.id != RDWG_ID_SC2_TX && fault.id != RDWG_ID_SC1_TX;
  endproperty
  a_tx: assert property (p_tx) else $error("tx");
  c_low: cover property (dma_gnt[5]);
  c_flt: cover property ($rose(fault.valid));
  c_err: cover property (hresp && hreadyout);
endmodule // rdwg_ram_guard_properties
bind rdwg_ram_guard rdwg_ram_guard_properties chk_u (.clk, .reset_n, .hresp, .hreadyout,
  .dma_guard_en, .dma_req, .dma_gnt, .fault_clear, .fault, .dma_fault_irq);

/* rdwg_dma_model.sv */
// dma master: holds a request until granted
// payload scrambled once released
`timescale 1ns/1ps
module rdwg_dma_model
  import rdwg_pkg::*;
(
  input wire logic clk,
  input wire logic start,
  input wire rdwg_dma_req_t cmd,
  input wire logic gnt,
  output rdwg_dma_req_t req
);
  initial req = '0;
  always @(posedge clk) begin
    if (start) begin
      req <= cmd;
    end else if (gnt) begin
      req <= {1'b0, ~req[$bits(rdwg_dma_req_t)-2:0]};
    end
  end
endmodule // rdwg_dma_model

/* rdwg_ram_guard_tb.sv */
// bench for rdwg_ram_guard
// six dma models drive the channels
`timescale 1ns/1ps
module rdwg_ram_guard_tb
  import rdwg_pkg::*;
;
  logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, fast = 1'b0, guard = 1'b0;
  logic bwe = 1'b0, bval = 1'b0, fclr = 1'b0, hreadyout, hresp, irq, rsp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, drd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] hprot = 4'h3;
  logic [7:0] bidx = 8'h0;
  logic [5:0] st = 6'h0, gnt;
  logic [255:0] bitmap;
  logic [2:0] gq [$];
  rdwg_fault_t fault;
  rdwg_dma_req_t cmd [6], dreq [6];
  int n_mismatch = 0, n_checks = 0, wt;
  always #2 clk = ~clk;
  rdwg_ram_guard dut_u (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hprot,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fast_clk_mode(fast),
    .dma_guard_en(guard), .bitmap_we(bwe), .bitmap_idx(bidx), .bitmap_val(bval), .bitmap,
    .dma_req(dreq), .dma_gnt(gnt), .dma_rdata(drd), .fault_clear(fclr), .dma_fault_irq(irq),
    .fault);
  for (genvar i = 0; i < 6; i++) begin : g_ch
    rdwg_dma_model m_u (.clk, .start(st[i]), .cmd(cmd[i]), .gnt(gnt[i]), .req(dreq[i]));
  end
  always @(posedge clk) for (int i = 0; i < 6; i++) if (gnt[i]) gq.push_back(3'(i));
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic stall;
    n_mismatch++;
    report_and_stop();
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d, input logic [3:0] p);
    @(negedge clk);
    {hsel, haddr, htrans, hwrite, hprot} = {1'b1, a, 2'h2, w, p};
    @(negedge clk);
    htrans = 2'h0;
    hwdata = d;
    for (wt = 0; hreadyout !== 1'b1 && wt < 9; wt++) @(negedge clk);
    if (wt == 9) stall();
    rsp = hresp;
    rd = hrdata;
  endtask
  task automatic dma(input logic [5:0] m);
    int n;
    @(negedge clk) st = m;
    @(negedge clk) st = 6'h0;
    for (n = 0; n < 40 && (dreq[0].req | dreq[1].req | dreq[2].req | dreq[3].req
        | dreq[4].req | dreq[5].req) !== 1'b0; n++) @(negedge clk);
    if (n == 40) stall();
  endtask
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    chk(bitmap === '0, 1'b1);
    ahb(1'b1, 32'h2000_1ffc, 32'h1234_5678, 4'h3);
    ahb(1'b0, 32'h2000_1ffc, 32'h0, 4'h3);
    chk(rd, 32'h1234_5678);
    hsize = 3'h0;
    ahb(1'b1, 32'h2000_1ffd, 32'h0000_ab00, 4'h3);
    hsize = 3'h1;
    ahb(1'b1, 32'h2000_1ffe, 32'hcdef_0000, 4'h3);
    hsize = 3'h2;
    ahb(1'b0, 32'h2000_1ffc, 32'h0, 4'h3);
    chk(rd, 32'hcdef_ab78);
    ahb(1'b1, 32'h2000_001c, 32'haa, 4'h3);
    @(negedge clk) {bwe, bidx, bval} = {1'b1, 8'h0, 1'b1};
    @(negedge clk) bwe = 1'b0;
    ahb(1'b1, 32'h2000_001c, 32'h55, 4'h1);
    chk(rsp, 1'b1);
    ahb(1'b0, 32'h2000_001c, 32'h0, 4'h1);
    chk(rd, 32'haa);
    ahb(1'b1, 32'h2000_0020, 32'h0, 4'h1);
    chk(rsp, 1'b0);
    ahb(1'b1, 32'h2000_001c, 32'h66, 4'h3);
    chk(rsp, 1'b0);
    fast = 1'b1;
    ahb(1'b1, 32'h2000_0040, 32'h1, 4'h3);
    chk(wt, 32'h2);
    fast = 1'b0;
    for (int i = 0; i < 6; i++) cmd[i] = '{1'b1, i % 3 != 2, 32'h2000_0100 + 32'(4 * i),
        RDWG_SZ_WORD, 32'(i)};
    dma(6'h3f);
    for (int i = 0; i < 6; i++) chk(gq[i], i);
    ahb(1'b0, 32'h2000_0110, 32'h0, 4'h3);
    chk(rd, 32'h4);
    cmd[5].addr = 32'h2000_0110;
    dma(6'h20);
    chk(drd, 32'h4);
    cmd[4] = '{1'b1, 1'b1, 32'h2000_0004, RDWG_SZ_WORD, 32'h11};
    dma(6'h10);
    chk(irq, 1'b0);
    guard = 1'b1;
    cmd[2].addr = 32'h2000_0008;
    cmd[2].write = 1'b1;
    dma(6'h04);
    chk(irq, 1'b0);
    cmd[4].wdata = 32'h22;
    dma(6'h10);
    chk(irq, 1'b1);
    chk(fault.id, RDWG_ID_SC1_RX);
    cmd[1] = '{1'b1, 1'b1, 32'h2000_000c, RDWG_SZ_WORD, 32'h0};
    dma(6'h02);
    chk(fault.addr, 32'h2000_0004);
    ahb(1'b0, 32'h2000_0004, 32'h0, 4'h3);
    chk(rd, 32'h11);
    @(negedge clk) fclr = 1'b1;
    @(negedge clk) fclr = 1'b0;
    chk(irq, 1'b0);
    report_and_stop();
  end
endmodule // rdwg_ram_guard_tb
